// file: hdl/mdsa_pkg.sv
package mdsa_pkg;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int NUM_DATA = 6;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_DATA0 = 8'hf9;
  localparam logic [7:0] IDX_DATA1 = 8'hfa;
  localparam logic [7:0] IDX_DATA2 = 8'hfb;
  localparam logic [7:0] IDX_DATA3 = 8'hfc;
  localparam logic [7:0] IDX_DATA4 = 8'hfd;
  localparam logic [7:0] IDX_DATA5 = 8'hfe;
  localparam logic [7:0] IDX_CTRL = 8'hff;
  // slot = index minus IDX_DATA0
  localparam logic [2:0] SLOT_B0 = 3'h0;
  localparam logic [2:0] SLOT_B1 = 3'h1;
  localparam logic [2:0] SLOT_B2 = 3'h2;
  localparam logic [2:0] SLOT_B3 = 3'h3;
  localparam logic [2:0] SLOT_B4 = 3'h4;
  localparam logic [2:0] SLOT_B5 = 3'h5;
  localparam logic [2:0] SLOT_CTRL = 3'h6;
  localparam int CTRL_ERR_BIT = 7;
  localparam int CTRL_OV_BIT = 6;
  localparam int CTRL_SLR_BIT = 5;
  localparam int SC_W = 5;
  localparam logic [SC_W-1:0] SC_NORM = 5'h00;
  localparam logic [SC_W-1:0] SC_MAX = 5'h1f;
  localparam logic [BYTE_W-1:0] DATA_RESET = 8'h00;
  localparam logic [WORD_W-1:0] MUL_LIMIT = 32'h0000_ffff;
  localparam int CNT_W = 5;
  localparam int LAT_DIV32 = 17;
  localparam int LAT_DIV16 = 9;
  localparam int LAT_MUL = 10;
  localparam logic [CNT_W-1:0] WAIT_DIV32 = CNT_W'(LAT_DIV32 - 1);
  localparam logic [CNT_W-1:0] WAIT_DIV16 = CNT_W'(LAT_DIV16 - 1);
  localparam logic [CNT_W-1:0] WAIT_MUL = CNT_W'(LAT_MUL - 1);
  localparam logic [CNT_W-1:0] STEPS_DIV32 = 5'h10;
  localparam logic [CNT_W-1:0] STEPS_DIV16 = 5'h08;
  typedef enum {OP_MUL, OP_DIV, OP_SHIFT, OP_NORM} mdsa_op_t;
  typedef enum {SEQ_IDLE, SEQ_LOAD, SEQ_BUSY, SEQ_RESULT} mdsa_seq_t;
endpackage : mdsa_pkg

// file: hdl/mdsa_eng_if.sv
`timescale 1ns/1ps
interface mdsa_eng_if import mdsa_pkg::*; ();
  logic divStart;
  logic divWide;
  logic [WORD_W-1:0] dividend;
  logic [HALF_W-1:0] divisor;
  logic [WORD_W-1:0] quotient;
  logic [HALF_W-1:0] remainder;
  logic shStart;
  logic shNorm;
  logic shRight;
  logic [SC_W-1:0] shCount;
  logic [WORD_W-1:0] shOperand;
  logic [WORD_W-1:0] shResult;
  logic [SC_W-1:0] shShifts;
  logic shDone;
  modport ctl (output divStart, divWide, dividend, divisor, shStart, shNorm,
    shRight, shCount, shOperand, input quotient, remainder, shResult,
    shShifts, shDone);
  modport div (input divStart, divWide, dividend, divisor,
    output quotient, remainder);
  modport sh (input shStart, shNorm, shRight, shCount, shOperand,
    output shResult, shShifts, shDone);
endinterface : mdsa_eng_if

// file: hdl/mdsa_divider.sv
`timescale 1ns/1ps
module mdsa_divider import mdsa_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  mdsa_eng_if.div eng
);
  logic [WORD_W-1:0] quoQ;
  logic [HALF_W-1:0] remQ;
  logic [HALF_W-1:0] dvsQ;
  logic [CNT_W-1:0] stepsQ;
  logic [HALF_W+WORD_W-1:0] stepD;

  // one restoring step: shift a dividend bit into the remainder
  function automatic logic [HALF_W+WORD_W-1:0] divStep(
    input logic [HALF_W+WORD_W-1:0] st, input logic [HALF_W-1:0] d);
    logic [HALF_W:0] r;
    logic [WORD_W-1:0] q;
    r = {st[HALF_W+WORD_W-1:WORD_W], st[WORD_W-1]};
    q = {st[WORD_W-2:0], 1'b0};
    if (r >= {1'b0, d}) begin
      r = r - {1'b0, d};
      q[0] = 1'b1;
    end
    return {r[HALF_W-1:0], q};
  endfunction : divStep

  // two bits per clock keeps 32/16 inside its cycle budget
  assign stepD = divStep(divStep({remQ, quoQ}, dvsQ), dvsQ);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      quoQ <= '0;
      remQ <= '0;
      dvsQ <= '0;
      stepsQ <= '0;
    end else if (clockEnable) begin
      if (eng.divStart) begin
        quoQ <= eng.divWide ? eng.dividend
                            : {eng.dividend[HALF_W-1:0], {HALF_W{1'b0}}};
        remQ <= '0;
        dvsQ <= eng.divisor;
        stepsQ <= eng.divWide ? STEPS_DIV32 : STEPS_DIV16;
      end else if (stepsQ != '0) begin
        {remQ, quoQ} <= stepD;
        stepsQ <= stepsQ - 1'b1;
      end
    end
  end

  assign eng.quotient = quoQ;
  assign eng.remainder = remQ;
endmodule : mdsa_divider

// file: hdl/mdsa_shifter.sv
`timescale 1ns/1ps
module mdsa_shifter import mdsa_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  mdsa_eng_if.sh eng
);
  logic [WORD_W-1:0] valQ;
  logic [SC_W-1:0] remQ;
  logic [SC_W-1:0] cntQ;
  logic busyQ;
  logic doneQ;
  logic normQ;
  logic rightQ;
  logic finished;
  logic [SC_W-1:0] amount;

  always_comb begin
    finished = normQ ? (valQ[WORD_W-1] || cntQ == SC_MAX) : (remQ == '0);
    if (normQ) begin
      amount = (valQ[WORD_W-1 -: 2] == 2'b00 && cntQ < SC_MAX - 1'b1)
               ? 5'h02 : 5'h01;
    end else begin
      amount = (remQ > 5'h01) ? 5'h02 : 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      valQ <= '0;
      remQ <= '0;
      cntQ <= '0;
      busyQ <= 1'b0;
      doneQ <= 1'b0;
      normQ <= 1'b0;
      rightQ <= 1'b0;
    end else if (clockEnable) begin
      doneQ <= 1'b0;
      if (eng.shStart) begin
        valQ <= eng.shOperand;
        remQ <= eng.shCount;
        cntQ <= '0;
        busyQ <= 1'b1;
        normQ <= eng.shNorm;
        rightQ <= eng.shRight;
      end else if (busyQ) begin
        if (finished) begin
          busyQ <= 1'b0;
          doneQ <= 1'b1;
        end else begin
          // normalize always shifts left
          valQ <= (rightQ && !normQ) ? valQ >> amount : valQ << amount;
          remQ <= remQ - amount;
          cntQ <= cntQ + amount;
        end
      end
    end
  end

  assign eng.shResult = valQ;
  assign eng.shShifts = cntQ;
  assign eng.shDone = doneQ;
endmodule : mdsa_shifter

// file: hdl/mdsa_top.sv
// Notes on behaviour
// - unsigned only: 16x16 multiply, 32/16 and 16/16 divide, shift, normalize.
// - no done flag; multiply and divide results appear a fixed count after last operand write, shift and normalize time grows with the shift count.
// - 32/16 divide gives 32-bit quotient, 16-bit remainder after 17 cycles.
// - 16/16 divide gives 16-bit quotient and remainder after 9 cycles.
// - 16x16 multiply gives 32-bit product after 10 cycles.
// - data write during an operation sets error bit 7; control read clears.
// - overflow bit 6 on product above 0xFFFF or division by zero.
// - overflow also set when normalizing an operand with top bit one.
// - control bit 5 picks shift direction, one is right, zero left.
// - zero shift count starts normalize, nonzero starts shift by that count.
// - normalize shifts left out leading zeros and reports the shift count.
// - first byte0 write restarts the load; divisor high write starts divide.
// - quotient in bytes 0-3, remainder in 4-5, then control read.
// - the last read of a division result readies the unit again.
// - product lands in bytes 0-3 low first, flags read afterwards.
// - normalize loads bytes 0-3 then a control write with zero count.
// - shift loads bytes 0-3, control write with count and direction.
// - an out-of-order write may abort the running operation.
// - control and all six data registers reset to zero.
`timescale 1ns/1ps
module mdsa_top import mdsa_pkg::*; #(
  parameter int ADDR_WIDTH = ADDR_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [WORD_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [WORD_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  mdsa_eng_if eng ();

  logic [BYTE_W-1:0] dataQ [NUM_DATA];
  logic errQ;
  logic ovQ;
  logic slrQ;
  logic [SC_W-1:0] scQ;
  logic [WORD_W-1:0] prdataQ;
  logic preadyQ;
  logic pslverrQ;
  mdsa_seq_t seqQ;
  mdsa_op_t opQ;
  logic [CNT_W-1:0] cntQ;
  logic [2:0] prevSlotQ;
  logic wideQ;

  logic [7:0] addrIdx;
  logic addrOk;
  logic [2:0] slot;
  logic setupPh;
  logic accessDone;
  logic wrData;
  logic wrCtrl;
  logic rdCtrl;
  logic busy;
  logic startMul;
  logic startDiv;
  logic startSh;
  logic seqErr;
  logic commit;
  logic ovCause;
  logic [WORD_W-1:0] operand;
  logic [WORD_W-1:0] product;
  logic [BYTE_W-1:0] ctrlView;
  logic [BYTE_W-1:0] readMux;
  logic [NUM_DATA*BYTE_W-1:0] resVec;
  logic [NUM_DATA-1:0] resMask;

  // ---------------- bus decode ----------------
  assign addrIdx = paddr[9:2];
  assign addrOk = (paddr[ADDR_WIDTH-1:10] == '0) && (paddr[1:0] == 2'b00)
                  && (addrIdx >= IDX_DATA0);
  assign slot = 3'(addrIdx - IDX_DATA0);
  assign setupPh = psel && !penable;
  assign accessDone = psel && penable && preadyQ;
  // only lane 0 carries register data
  assign wrData = accessDone && pwrite && addrOk && pstrb[0]
                  && (slot != SLOT_CTRL);
  assign wrCtrl = accessDone && pwrite && addrOk && pstrb[0]
                  && (slot == SLOT_CTRL);
  assign rdCtrl = accessDone && !pwrite && addrOk && (slot == SLOT_CTRL);

  assign busy = (seqQ == SEQ_BUSY);
  assign operand = {dataQ[3], dataQ[2], dataQ[1], dataQ[0]};
  assign product = {dataQ[1], dataQ[0]} * {dataQ[5], dataQ[4]};

  // ---------------- operation starts ----------------
  // multiply is told from divide by the write just before byte5
  assign startMul = wrData && (slot == SLOT_B5) && (seqQ == SEQ_LOAD)
                    && (prevSlotQ == SLOT_B1);
  assign startDiv = wrData && (slot == SLOT_B5) && (seqQ == SEQ_LOAD)
                    && (prevSlotQ == SLOT_B4);
  assign startSh = wrCtrl && !busy;
  assign seqErr = wrData && busy;

  always_comb begin
    commit = 1'b0;
    if (busy) begin
      if (opQ == OP_SHIFT || opQ == OP_NORM) begin
        commit = eng.shDone;
      end else begin
        commit = (cntQ == '0);
      end
    end
  end

  always_comb begin
    ovCause = 1'b0;
    case (opQ)
      OP_MUL: ovCause = (product > MUL_LIMIT);
      OP_DIV: ovCause = ({dataQ[5], dataQ[4]} == '0);
      OP_NORM: ovCause = operand[WORD_W-1];
      default: ovCause = 1'b0;
    endcase
  end

  // the divisor high byte is still on the bus when the divide starts
  assign eng.divStart = startDiv;
  assign eng.divWide = wideQ;
  assign eng.dividend = operand;
  assign eng.divisor = {pwdata[BYTE_W-1:0], dataQ[4]};
  assign eng.shStart = startSh;
  assign eng.shNorm = (pwdata[SC_W-1:0] == SC_NORM);
  assign eng.shRight = pwdata[CTRL_SLR_BIT];
  assign eng.shCount = pwdata[SC_W-1:0];
  assign eng.shOperand = operand;

  mdsa_divider u_divider (
    .clock(clock),
    .rst_n(rst_n),
    .clockEnable(clockEnable),
    .eng(eng.div)
  );

  mdsa_shifter u_shifter (
    .clock(clock),
    .rst_n(rst_n),
    .clockEnable(clockEnable),
    .eng(eng.sh)
  );

  // ---------------- results ----------------
  always_comb begin
    resVec = '0;
    resMask = '0;
    case (opQ)
      OP_MUL: begin
        resVec[WORD_W-1:0] = product;
        resMask = 6'h0f;
      end
      OP_DIV: begin
        resVec = {eng.remainder, eng.quotient};
        resMask = 6'h3f;
      end
      default: begin
        resVec[WORD_W-1:0] = eng.shResult;
        resMask = 6'h0f;
      end
    endcase
  end

  for (genvar i = 0; i < NUM_DATA; i++) begin : g_data
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        dataQ[i] <= DATA_RESET;
      end else if (clockEnable) begin
        // a write during an operation wins and aborts it; a result committed in the same cycle still fills the other bytes
        if (wrData && slot == 3'(i)) begin
          dataQ[i] <= pwdata[BYTE_W-1:0];
        end else if (commit && resMask[i]) begin
          dataQ[i] <= resVec[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ---------------- load sequence tracking ----------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prevSlotQ <= SLOT_CTRL;
      wideQ <= 1'b0;
    end else if (clockEnable) begin
      if (wrData) begin
        prevSlotQ <= slot;
        if (slot == SLOT_B0) begin
          wideQ <= 1'b0;
        end else if (slot == SLOT_B2 || slot == SLOT_B3) begin
          wideQ <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seqQ <= SEQ_IDLE;
    end else if (clockEnable) begin
      case (seqQ)
        SEQ_IDLE, SEQ_RESULT: begin
          if (startSh) begin
            seqQ <= SEQ_BUSY;
          end else if (wrData && slot == SLOT_B0) begin
            seqQ <= SEQ_LOAD;
          end else if (rdCtrl && seqQ == SEQ_RESULT) begin
            seqQ <= SEQ_IDLE;
          end
        end
        SEQ_LOAD: begin
          if (startMul || startDiv || startSh) begin
            seqQ <= SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          if (seqErr) begin
            // abort; a byte0 write counts as the start of a new load
            seqQ <= (slot == SLOT_B0) ? SEQ_LOAD : SEQ_IDLE;
          end else if (commit) begin
            seqQ <= SEQ_RESULT;
          end
        end
        default: seqQ <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      opQ <= OP_MUL;
      cntQ <= '0;
    end else if (clockEnable) begin
      if (startMul) begin
        opQ <= OP_MUL;
        cntQ <= WAIT_MUL;
      end else if (startDiv) begin
        opQ <= OP_DIV;
        cntQ <= wideQ ? WAIT_DIV32 : WAIT_DIV16;
      end else if (startSh) begin
        opQ <= eng.shNorm ? OP_NORM : OP_SHIFT;
        cntQ <= '0;
      end else if (busy && cntQ != '0) begin
        cntQ <= cntQ - 1'b1;
      end
    end
  end

  // ---------------- control / status ----------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slrQ <= 1'b0;
      scQ <= '0;
    end else if (clockEnable) begin
      if (startSh) begin
        slrQ <= pwdata[CTRL_SLR_BIT];
        scQ <= pwdata[SC_W-1:0];
      end else if (commit && opQ == OP_NORM) begin
        scQ <= eng.shShifts;
      end
    end
  end

  // only the bits that a read actually returned are cleared, and a
  // new event in the clearing cycle still sets the flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      errQ <= 1'b0;
    end else if (clockEnable) begin
      errQ <= seqErr || (errQ && !(rdCtrl && prdataQ[CTRL_ERR_BIT]));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ovQ <= 1'b0;
    end else if (clockEnable) begin
      ovQ <= (commit && ovCause && !seqErr)
             || (ovQ && !(rdCtrl && prdataQ[CTRL_OV_BIT]));
    end
  end

  // ---------------- bus answer ----------------
  assign ctrlView = {errQ, ovQ, slrQ, scQ};

  always_comb begin
    if (slot == SLOT_CTRL) begin
      readMux = ctrlView;
    end else if (slot < SLOT_CTRL) begin
      readMux = dataQ[slot];
    end else begin
      readMux = '0;
    end
  end

  // data is captured at the end of setup so pready and prdata are flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdataQ <= '0;
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
    end else if (clockEnable) begin
      if (setupPh) begin
        prdataQ <= addrOk ? {{(WORD_W-BYTE_W){1'b0}}, readMux} : '0;
        preadyQ <= 1'b1;
        pslverrQ <= !addrOk;
      end else begin
        preadyQ <= 1'b0;
        pslverrQ <= 1'b0;
      end
    end
  end

  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = pslverrQ;
endmodule : mdsa_top

// file: testbench/mdsa_assertions.sv
`timescale 1ns/1ps
module mdsa_checker import mdsa_pkg::*; #(
  parameter int ADDR_WIDTH = ADDR_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [WORD_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [WORD_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic mapped;
  logic setup;
  assign mapped = paddr[ADDR_WIDTH-1:10] == '0 && paddr[1:0] == 2'b00
    && paddr[9:2] >= IDX_DATA0;
  assign setup = psel && !penable && clockEnable;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_clears: assert property (
    $rose(rst_n) |-> prdata == '0 && !pready && !pslverr)
    else $error("outputs not cleared by reset");
  a_ready_after_setup: assert property (
    setup |=> pready) else $error("no answer after setup");
  a_ready_single: assert property (
    pready && clockEnable |=> !pready) else $error("ready held too long");
  a_ready_cause: assert property (
    $rose(pready) |-> $past(psel && !penable))
    else $error("ready without setup");
  a_byte_wide: assert property (
    pready |-> prdata[31:8] == '0) else $error("upper read bits set");
  a_unmapped_err: assert property (
    setup && !mapped |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (
    setup && mapped |=> !pslverr) else $error("mapped access refused");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  a_rdata_hold: assert property (
    !pready && $past(rst_n) |-> $stable(prdata))
    else $error("read data moved while idle");
  a_enable_freeze: assert property (
    !clockEnable |=> $stable(pready) && $stable(prdata) && $stable(pslverr))
    else $error("outputs moved while frozen");
endmodule : mdsa_checker

bind mdsa_top mdsa_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: testbench/mdsa_cpu_model.sv
`timescale 1ns/1ps
module mdsa_cpu_model import mdsa_pkg::*; (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [WORD_W-1:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [WORD_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end
  // called at a rising edge; returns one edge after the answer was taken
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [7:0] d, output logic [7:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus must not keep looking valid
    pwdata <= ~pwdata;
    paddr <= ~paddr;
    // idle edge: a following call must not drive psel again in this step
    @(posedge clock);
  endtask : xfer
endmodule : mdsa_cpu_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench import mdsa_pkg::*;;
  typedef struct {logic [2:0] k; logic [31:0] a; logic [15:0] b;} mdsa_row_t;
  logic clock = 1'b0, rst_n = 1'b0, clockEnable = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [ADDR_W-1:0] paddr;
  logic [WORD_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] q;
  int failures = 0, total_checks = 0, cycles = 0;
  // kind: 0 mul, 1 div32, 2 div16, 3 shift, 4 normalize
  mdsa_row_t rows[13] = '{
    '{0, 32'h0000_ffff, 16'hffff}, '{0, 32'h0000_0100, 16'h00ff},
    '{0, 32'h0000_0100, 16'h0100}, '{1, 32'h1234_5678, 16'h0009},
    '{2, 32'h0000_fffe, 16'h0003}, '{1, 32'h8765_4321, 16'h0000},
    '{3, 32'h8000_0001, 16'h0001}, '{3, 32'h8000_0001, 16'h003f},
    '{3, 32'h0000_0001, 16'h001f}, '{4, 32'h0000_0001, 16'h0000},
    '{4, 32'h8000_0000, 16'h0000}, '{4, 32'h0000_0000, 16'h0000},
    '{4, 32'h0012_3400, 16'h0000}};
  always #12.5 clock = ~clock;
  mdsa_top u_dut (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  mdsa_cpu_model u_cpu (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic complete_run;
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_cpu.xfer(1'b1, idx, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] x,
    input logic [7:0] m);
    u_cpu.xfer(1'b0, idx, 8'h00, q, e);
    chk(q & m, x & m);
  endtask : rd
  task automatic run(input mdsa_row_t r);
    logic [31:0] er, dd;
    logic [15:0] rr;
    logic ov;
    int sc, n;
    ov = 1'b0;
    sc = 0;
    rr = 16'h0000;
    dd = r.a;
    if (r.k == 0) begin
      wr(IDX_DATA0, r.a[7:0]);
      wr(IDX_DATA4, r.b[7:0]);
      wr(IDX_DATA1, r.a[15:8]);
      wr(IDX_DATA5, r.b[15:8]);
      er = r.a[15:0] * r.b;
      ov = er > MUL_LIMIT;
      n = LAT_MUL;
    end else begin
      for (int i = 0; i < 4; i++)
        if (r.k != 2 || i < 2) wr(8'(IDX_DATA0 + i), r.a[8*i+:8]);
      if (r.k < 3) begin
        wr(IDX_DATA4, r.b[7:0]);
        wr(IDX_DATA5, r.b[15:8]);
        if (r.k == 2) dd = {16'h0000, r.a[15:0]};
        n = (r.k == 2) ? LAT_DIV16 : LAT_DIV32;
        if (r.b == 16'h0000) begin
          er = (r.k == 2) ? 32'h0000_ffff : 32'hffff_ffff;
          rr = r.a[15:0];
          ov = 1'b1;
        end else begin
          er = dd / r.b;
          rr = 16'(dd % r.b);
        end
      end else begin
        wr(IDX_CTRL, r.b[7:0]);
        if (r.k == 3) begin
          sc = r.b[4:0];
          er = r.b[5] ? r.a >> sc : r.a << sc;
        end else if (r.a == 32'h0000_0000) begin
          sc = 31;
          er = 32'h0000_0000;
        end else if (r.a[31]) begin
          ov = 1'b1;
          er = r.a;
        end else begin
          while (!r.a[31-sc]) sc++;
          er = r.a << sc;
        end
        n = (sc + 1) / 2 + 2;
      end
    end
    repeat (n) @(posedge clock);
    for (int i = 0; i < 4; i++)
      if (r.k != 2 || i < 2)
        rd(8'(IDX_DATA0 + i), er[8*i+:8], 8'hff);
    if (r.k == 1 || r.k == 2) begin
      rd(IDX_DATA4, rr[7:0], 8'hff);
      rd(IDX_DATA5, rr[15:8], 8'hff);
    end
    rd(IDX_CTRL, {1'b0, ov, r.k == 3 && r.b[5], 5'(sc)},
      (r.k < 3) ? 8'hc0 : 8'hff);
  endtask : run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) run(rows[i]);
    // multiply interrupted by a fresh first-byte write
    wr(IDX_DATA0, 8'h01);
    wr(IDX_DATA4, 8'h02);
    wr(IDX_DATA1, 8'h00);
    wr(IDX_DATA5, 8'h00);
    wr(IDX_DATA0, 8'h05);
    rd(IDX_CTRL, 8'h80, 8'h80);
    rd(IDX_CTRL, 8'h00, 8'h80);
    wr(IDX_CTRL, 8'hc3);
    repeat (4) @(posedge clock);
    rd(IDX_CTRL, 8'h03, 8'hff);
    u_cpu.xfer(1'b0, 8'hf8, 8'h00, q, e);
    chk(e, 1'b1);
    chk(q, 8'h00);
    clockEnable <= 1'b0;
    repeat (3) @(posedge clock);
    clockEnable <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 7; i++) rd(8'(IDX_DATA0 + i), 8'h00, 8'hff);
    complete_run();
  end
endmodule : testbench
